/* File: afc_defs.svh */
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH

// ----------------------------------------
// byte values
// ----------------------------------------
`define AFC_DELIM 8'h7e
`define AFC_ESC 8'h7d
`define AFC_ESC_XOR 8'h20
`define AFC_XON 8'h11
`define AFC_XOFF 8'h13
`define AFC_SUM_GOOD 8'hff

// ----------------------------------------
// mode selector values
// ----------------------------------------
`define AFC_MODE_TRANSP 2'h0
`define AFC_MODE_PLAIN 2'h1
`define AFC_MODE_ESCAPED 2'h2

// ----------------------------------------
// sizes
// ----------------------------------------
`define AFC_BUF_AW 8
`define AFC_BUF_DEPTH 256
`define AFC_BUF_MAX 16'h0100
`define AFC_FIFO_DEPTH 8
`define AFC_FIFO_W 10

`endif

/* File: afc_pkg.sv */
package afc_pkg;

    typedef enum logic [2:0] {
        AFC_RX_IDLE = 3'b000,
        AFC_RX_LEN_HI = 3'b001,
        AFC_RX_LEN_LO = 3'b010,
        AFC_RX_DATA = 3'b011,
        AFC_RX_CSUM = 3'b100,
        AFC_RX_REPLAY = 3'b101
    } afc_rx_state_t;

    typedef enum logic [2:0] {
        AFC_TX_IDLE = 3'b000,
        AFC_TX_DELIM = 3'b001,
        AFC_TX_LEN_HI = 3'b010,
        AFC_TX_LEN_LO = 3'b011,
        AFC_TX_DATA = 3'b100,
        AFC_TX_CSUM = 3'b101
    } afc_tx_state_t;

endpackage

/* File: afc_stream_if.sv */
`timescale 1ns/1ns
interface afc_stream_if #(
    parameter int W = 10
);
    logic valid;
    logic ready;
    logic [W-1:0] data;

    modport src (
        output valid,
        output data,
        input ready
    );

    modport snk (
        input valid,
        input data,
        output ready
    );
endinterface

/* File: afc_fifo.sv */
`timescale 1ns/1ns
module afc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // fill side
    afc_stream_if.snk wr,
    // drain side
    afc_stream_if.src rd,
    // at least two free words after this edge
    output logic space_ok
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [CW-1:0] count_q, count_d;
    logic space_q, space_d;
    logic push, pop;

    assign wr.ready = (count_q != CW'(DEPTH));
    assign rd.valid = (count_q != '0);
    assign rd.data = mem[rd_ptr_q];
    assign space_ok = space_q;

    always_comb begin
        push = wr.valid && wr.ready;
        pop = rd.valid && rd.ready;
        wr_ptr_d = push ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
        rd_ptr_d = pop ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
        count_d = count_q;
        if (push && !pop) begin
            count_d = CW'(count_q + 1'b1);
        end else if (pop && !push) begin
            count_d = CW'(count_q - 1'b1);
        end
        space_d = (count_d <= CW'(DEPTH - 2));
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            space_q <= 1'b1;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            space_q <= space_d;
        end
    end

    // storage has no reset; only words below count are ever read
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_q] <= wr.data;
        end
    end
endmodule

/* File: afc_codec.sv */
`timescale 1ns/1ns
`include "afc_defs.svh"
module afc_codec
    import afc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // configuration
    input wire logic [1:0] api_mode_select,
    // serial receive bytes
    input wire logic uart_rx_valid,
    input wire logic [7:0] uart_rx_byte,
    output logic uart_rx_ready,
    // serial transmit bytes
    output logic uart_tx_valid,
    output logic [7:0] uart_tx_byte,
    input wire logic uart_tx_ready,
    // delivered frame data
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_first,
    output logic rx_last,
    input wire logic rx_ready,
    output logic rx_frame_ok,
    output logic rx_frame_err,
    // frame data to send
    input wire logic tx_start,
    input wire logic [15:0] tx_len,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    output logic tx_busy
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic needs_esc(input logic [7:0] b);
        needs_esc = (b == `AFC_DELIM) || (b == `AFC_ESC) ||
                    (b == `AFC_XON) || (b == `AFC_XOFF);
    endfunction

    function automatic logic is_framed(input logic [1:0] m);
        is_framed = (m == `AFC_MODE_PLAIN) || (m == `AFC_MODE_ESCAPED);
    endfunction

    // ----------------------------------------
    // receive parser
    // ----------------------------------------
    afc_stream_if #(.W(`AFC_FIFO_W)) rx_in ();
    afc_stream_if #(.W(`AFC_FIFO_W)) rx_out ();
    logic space_ok;

    // frame held here until its checksum proves good
    logic [7:0] frame_buf [`AFC_BUF_DEPTH];
    afc_rx_state_t rx_st_q, rx_st_d;
    logic [15:0] len_q, len_d;
    logic [8:0] idx_q, idx_d;
    logic [7:0] sum_q, sum_d;
    logic esc_q, esc_d;
    logic rdy_q, rdy_d;
    logic ok_q, ok_d, err_q, err_d;
    logic push_v;
    logic [`AFC_FIFO_W-1:0] push_w;
    logic wr_en;
    logic [7:0] b;
    logic take, framed, escm;

    always_comb begin
        rx_st_d = rx_st_q;
        len_d = len_q;
        idx_d = idx_q;
        sum_d = sum_q;
        esc_d = esc_q;
        ok_d = 1'b0;
        err_d = 1'b0;
        push_v = 1'b0;
        push_w = '0;
        wr_en = 1'b0;
        take = uart_rx_valid && rdy_q;
        framed = is_framed(api_mode_select);
        escm = (api_mode_select == `AFC_MODE_ESCAPED);
        b = (escm && esc_q) ? (uart_rx_byte ^ `AFC_ESC_XOR) : uart_rx_byte;
        if (take && !framed) begin
            push_v = 1'b1;
            push_w = {2'b00, uart_rx_byte};
            rx_st_d = AFC_RX_IDLE;
        end else if (take && escm && uart_rx_byte == `AFC_DELIM) begin
            err_d = (rx_st_q != AFC_RX_IDLE);
            rx_st_d = AFC_RX_LEN_HI;
            esc_d = 1'b0;
        end else if (take && escm && uart_rx_byte == `AFC_ESC && !esc_q
                     && rx_st_q != AFC_RX_IDLE) begin
            esc_d = 1'b1;
        end else if (take) begin
            esc_d = 1'b0;
            case (rx_st_q)
                AFC_RX_IDLE: begin
                    if (uart_rx_byte == `AFC_DELIM) begin
                        rx_st_d = AFC_RX_LEN_HI;
                    end
                end // other bytes fall away here
                AFC_RX_LEN_HI: begin
                    len_d = {b, len_q[7:0]};
                    rx_st_d = AFC_RX_LEN_LO;
                end
                AFC_RX_LEN_LO: begin
                    len_d = {len_q[15:8], b};
                    idx_d = '0;
                    sum_d = '0;
                    // no room for a type byte, or too long to hold
                    if (len_d == 16'h0000 || len_d > `AFC_BUF_MAX) begin
                        err_d = 1'b1;
                        rx_st_d = AFC_RX_IDLE;
                    end else begin
                        rx_st_d = AFC_RX_DATA;
                    end
                end
                AFC_RX_DATA: begin
                    wr_en = 1'b1;
                    sum_d = 8'(sum_q + b);
                    idx_d = 9'(idx_q + 1'b1);
                    if (16'(idx_d) == len_q) begin
                        rx_st_d = AFC_RX_CSUM;
                    end
                end
                AFC_RX_CSUM: begin
                    idx_d = '0;
                    if (8'(sum_q + b) == `AFC_SUM_GOOD) begin
                        ok_d = 1'b1;
                        rx_st_d = AFC_RX_REPLAY;
                    end else begin
                        err_d = 1'b1;
                        rx_st_d = AFC_RX_IDLE;
                    end
                end
                default: begin
                    rx_st_d = rx_st_q;
                end
            endcase
        end
        // in modes 1 and 2 only checked frames reach the fifo; mode 0 pushes raw bytes
        if (rx_st_q == AFC_RX_REPLAY && rx_in.ready) begin
            push_v = 1'b1;
            push_w = {idx_q == 9'h000, 16'(idx_q) == 16'(len_q - 1'b1),
                      frame_buf[idx_q[`AFC_BUF_AW-1:0]]};
            idx_d = 9'(idx_q + 1'b1);
            if (16'(idx_q) == 16'(len_q - 1'b1)) begin
                rx_st_d = AFC_RX_IDLE;
            end
        end
        // registered ready lags one cycle; the two-word margin lets the fifo fill to the last word
        rdy_d = (rx_st_d != AFC_RX_REPLAY) && space_ok;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_st_q <= AFC_RX_IDLE;
            len_q <= '0;
            idx_q <= '0;
            sum_q <= '0;
            esc_q <= 1'b0;
            rdy_q <= 1'b0;
            ok_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            len_q <= len_d;
            idx_q <= idx_d;
            sum_q <= sum_d;
            esc_q <= esc_d;
            rdy_q <= rdy_d;
            ok_q <= ok_d;
            err_q <= err_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            frame_buf[idx_q[`AFC_BUF_AW-1:0]] <= b;
        end
    end

    assign rx_in.valid = push_v;
    assign rx_in.data = push_w;
    assign uart_rx_ready = rdy_q;
    assign rx_frame_ok = ok_q;
    assign rx_frame_err = err_q;

    afc_fifo #(.WIDTH(`AFC_FIFO_W), .DEPTH(`AFC_FIFO_DEPTH)) u_rx_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr(rx_in),
        .rd(rx_out),
        .space_ok(space_ok)
    );

    // ----------------------------------------
    // receive output stage
    // ----------------------------------------
    logic ov_q, ov_d;
    logic [`AFC_FIFO_W-1:0] ow_q, ow_d;

    always_comb begin
        rx_out.ready = !ov_q || rx_ready;
        ov_d = ov_q;
        ow_d = ow_q;
        if (rx_out.ready) begin
            ov_d = rx_out.valid;
            ow_d = rx_out.data;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ov_q <= 1'b0;
            ow_q <= '0;
        end else begin
            ov_q <= ov_d;
            ow_q <= ow_d;
        end
    end

    assign rx_valid = ov_q;
    assign rx_first = ow_q[9];
    assign rx_last = ow_q[8];
    assign rx_data = ow_q[7:0];

    // ----------------------------------------
    // transmit framer
    // ----------------------------------------
    afc_tx_state_t tx_st_q, tx_st_d;
    logic [15:0] tlen_q, tlen_d, tcnt_q, tcnt_d;
    logic [7:0] tsum_q, tsum_d;
    logic pend_q, pend_d;
    logic [7:0] pend_b_q, pend_b_d;
    logic out_v_q, out_v_d;
    logic [7:0] out_b_q, out_b_d;
    logic trdy_q, trdy_d;
    logic tbusy_q, tbusy_d;
    logic em_req, em_raw, free, tacc;
    logic [7:0] em_b;

    always_comb begin
        tx_st_d = tx_st_q;
        tlen_d = tlen_q;
        tcnt_d = tcnt_q;
        tsum_d = tsum_q;
        pend_d = pend_q;
        pend_b_d = pend_b_q;
        out_v_d = out_v_q;
        out_b_d = out_b_q;
        em_req = 1'b0;
        em_raw = 1'b0;
        em_b = '0;
        free = !out_v_q || uart_tx_ready;
        tacc = tx_valid && trdy_q;
        if (free) begin
            out_v_d = 1'b0;
        end
        if (free && pend_q) begin
            out_v_d = 1'b1;
            out_b_d = pend_b_q;
            pend_d = 1'b0;
        end else if (free) begin
            case (tx_st_q)
                AFC_TX_IDLE: begin
                    if (!is_framed(api_mode_select)) begin
                        em_req = tacc;
                        em_raw = 1'b1;
                        em_b = tx_data;
                    end else if (tx_start) begin
                        tlen_d = tx_len;
                        tx_st_d = AFC_TX_DELIM;
                    end
                end
                AFC_TX_DELIM: begin
                    em_req = 1'b1;
                    em_raw = 1'b1; // leading delimiter never escaped
                    em_b = `AFC_DELIM;
                    tx_st_d = AFC_TX_LEN_HI;
                end
                AFC_TX_LEN_HI: begin
                    em_req = 1'b1;
                    em_b = tlen_q[15:8];
                    tx_st_d = AFC_TX_LEN_LO;
                end
                AFC_TX_LEN_LO: begin
                    em_req = 1'b1;
                    em_b = tlen_q[7:0];
                    tcnt_d = '0;
                    tsum_d = '0;
                    tx_st_d = (tlen_q == 16'h0000) ? AFC_TX_CSUM : AFC_TX_DATA;
                end
                AFC_TX_DATA: begin
                    if (tacc) begin
                        em_req = 1'b1;
                        em_b = tx_data;
                        tsum_d = 8'(tsum_q + tx_data);
                        tcnt_d = 16'(tcnt_q + 1'b1);
                        if (tcnt_d == tlen_q) begin
                            tx_st_d = AFC_TX_CSUM;
                        end
                    end
                end
                AFC_TX_CSUM: begin
                    em_req = 1'b1;
                    em_b = 8'(`AFC_SUM_GOOD - tsum_q);
                    tx_st_d = AFC_TX_IDLE;
                end
                default: begin
                    tx_st_d = AFC_TX_IDLE;
                end
            endcase
        end
        if (em_req) begin
            out_v_d = 1'b1;
            // mode 1 sends every byte as is
            if (!em_raw && api_mode_select == `AFC_MODE_ESCAPED && needs_esc(em_b)) begin
                out_b_d = `AFC_ESC;
                pend_d = 1'b1;
                pend_b_d = em_b ^ `AFC_ESC_XOR;
            end else begin
                out_b_d = em_b;
            end
        end
        // xon and xoff are escaped in mode 2 only, never obeyed
        trdy_d = !out_v_d && !pend_d &&
                 (tx_st_d == AFC_TX_DATA ||
                  (tx_st_d == AFC_TX_IDLE && !is_framed(api_mode_select)));
        tbusy_d = (tx_st_d != AFC_TX_IDLE) || pend_d;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_st_q <= AFC_TX_IDLE;
            tlen_q <= '0;
            tcnt_q <= '0;
            tsum_q <= '0;
            pend_q <= 1'b0;
            pend_b_q <= '0;
            out_v_q <= 1'b0;
            out_b_q <= '0;
            trdy_q <= 1'b0;
            tbusy_q <= 1'b0;
        end else begin
            tx_st_q <= tx_st_d;
            tlen_q <= tlen_d;
            tcnt_q <= tcnt_d;
            tsum_q <= tsum_d;
            pend_q <= pend_d;
            pend_b_q <= pend_b_d;
            out_v_q <= out_v_d;
            out_b_q <= out_b_d;
            trdy_q <= trdy_d;
            tbusy_q <= tbusy_d;
        end
    end

    assign uart_tx_valid = out_v_q;
    assign uart_tx_byte = out_b_q;
    assign tx_ready = trdy_q;
    assign tx_busy = tbusy_q;
endmodule

/* File: afc_codec_assertions.sv */
`timescale 1ns/1ns
module afc_codec_assertions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // watched ports
    input wire logic [1:0] api_mode_select,
    input wire logic uart_rx_ready,
    input wire logic uart_tx_valid,
    input wire logic [7:0] uart_tx_byte,
    input wire logic uart_tx_ready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_first,
    input wire logic rx_last,
    input wire logic rx_ready,
    input wire logic rx_frame_ok,
    input wire logic rx_frame_err,
    input wire logic tx_busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ----
    // escape seen on the wire, partner byte due
    // ----
    logic esc_q;
    logic esc_d;
    always_comb begin
        esc_d = esc_q;
        if (uart_tx_valid && uart_tx_ready) begin
            esc_d = api_mode_select == 2'h2 && !esc_q && uart_tx_byte == 8'h7d;
        end
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            esc_q <= 1'b0;
        end else begin
            esc_q <= esc_d;
        end
    end
    sequence tx_stall;
        uart_tx_valid && !uart_tx_ready;
    endsequence
    sequence start_seen;
        $rose(tx_busy);
    endsequence
    tx_hold_a: assert property (tx_stall |=> uart_tx_valid && $stable(uart_tx_byte))
        else $error("serial byte changed while stalled");
    rx_hold_a: assert property (rx_valid && !rx_ready |=>
        rx_valid && $stable({rx_data, rx_first, rx_last})) else $error("delivered byte lost");
    transp_flags_a: assert property (api_mode_select == 2'h0 && rx_valid |->
        !rx_first && !rx_last) else $error("frame marks in transparent mode");
    ok_err_excl_a: assert property (!(rx_frame_ok && rx_frame_err))
        else $error("frame both good and bad");
    ok_pulse_a: assert property (rx_frame_ok |=> !rx_frame_ok)
        else $error("frame good pulse too long");
    ok_stall_a: assert property (rx_frame_ok |-> !uart_rx_ready)
        else $error("receive open during replay");
    esc_pair_a: assert property (esc_q && uart_tx_valid && uart_tx_ready |->
        uart_tx_byte inside {8'h5e, 8'h5d, 8'h31, 8'h33}) else $error("bad escaped byte");
    no_flow_a: assert property (api_mode_select == 2'h2 && uart_tx_valid |->
        !(uart_tx_byte inside {8'h11, 8'h13})) else $error("raw flow byte sent");
    delim_first_a: assert property (start_seen |=>
        uart_tx_valid && uart_tx_byte == 8'h7e) else $error("frame not opened by delimiter");
endmodule

/* File: afc_host_model.sv */
`timescale 1ns/1ns
module afc_host_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bytes toward the codec
    output logic uart_rx_valid,
    output logic [7:0] uart_rx_byte,
    input wire logic uart_rx_ready,
    // bytes from the codec
    input wire logic uart_tx_valid,
    input wire logic [7:0] uart_tx_byte,
    output logic uart_tx_ready
);
    int seed = 32'h3d85cce8;
    logic [7:0] cap_q[$];
    logic refused = 1'b0;
    initial begin
        uart_rx_valid = 1'b0;
        uart_rx_byte = 8'h00;
        uart_tx_ready = 1'b0;
    end
    // ----
    // sender: bytes come prebuilt, gaps at random
    // ----
    // line idles inverted so a stale byte never looks valid
    task automatic send(input logic [7:0] q[$]);
        foreach (q[i]) begin
            uart_rx_valid <= 1'b1;
            uart_rx_byte <= q[i];
            @(posedge sys_clk);
            while (!uart_rx_ready) begin
                refused = 1'b1;
                @(posedge sys_clk);
            end
            if ($random(seed) % 4 == 0) begin
                uart_rx_valid <= 1'b0;
                uart_rx_byte <= ~q[i];
                @(posedge sys_clk);
            end
        end
        uart_rx_valid <= 1'b0;
        uart_rx_byte <= ~uart_rx_byte;
        @(posedge sys_clk);
    endtask
    // ----
    // receiver: stalls at random, keeps every byte
    // ----
    always @(posedge sys_clk) begin
        if (rst) begin
            uart_tx_ready <= 1'b0;
        end else begin
            uart_tx_ready <= $random(seed) % 3 != 0;
            if (uart_tx_valid && uart_tx_ready) begin
                cap_q.push_back(uart_tx_byte);
            end
        end
    end
endmodule

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
    typedef logic [7:0] afc_bq_t[$];
    logic sys_clk, rst, uart_rx_valid, uart_rx_ready, uart_tx_valid, uart_tx_ready;
    logic rx_valid, rx_first, rx_last, rx_ready, rx_frame_ok, rx_frame_err;
    logic tx_start, tx_valid, tx_ready, tx_busy, hold_rx;
    logic [1:0] api_mode_select;
    logic [7:0] uart_rx_byte, uart_tx_byte, rx_data, tx_data;
    logic [15:0] tx_len;
    int seed = 32'h3d85cce8;
    int n_fail = 0;
    int cmp_count = 0;
    int n_ok = 0;
    int n_err = 0;
    int ok_exp = 0;
    int err_exp = 0;
    logic [9:0] got_q[$];
    logic [9:0] exp_q[$];
    logic [7:0] sp[4] = '{8'h7e, 8'h7d, 8'h11, 8'h13};
    afc_codec dut_u (.sys_clk(sys_clk), .rst(rst), .api_mode_select(api_mode_select),
        .uart_rx_valid(uart_rx_valid), .uart_rx_byte(uart_rx_byte), .uart_rx_ready(uart_rx_ready),
        .uart_tx_valid(uart_tx_valid), .uart_tx_byte(uart_tx_byte), .uart_tx_ready(uart_tx_ready),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last),
        .rx_ready(rx_ready), .rx_frame_ok(rx_frame_ok), .rx_frame_err(rx_frame_err),
        .tx_start(tx_start), .tx_len(tx_len), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .tx_busy(tx_busy));
    afc_host_model host_u (.sys_clk(sys_clk), .rst(rst), .uart_rx_valid(uart_rx_valid),
        .uart_rx_byte(uart_rx_byte), .uart_rx_ready(uart_rx_ready), .uart_tx_valid(uart_tx_valid),
        .uart_tx_byte(uart_tx_byte), .uart_tx_ready(uart_tx_ready));
    always #5 sys_clk = ~sys_clk;
    // ----
    // consumer side: random stalls, collect everything delivered
    // ----
    always @(posedge sys_clk) begin
        rx_ready <= hold_rx ? 1'b0 : 1'($random(seed));
        if (!rst && rx_valid && rx_ready) got_q.push_back({rx_first, rx_last, rx_data});
        if (!rst && rx_frame_ok === 1'b1) n_ok++;
        if (!rst && rx_frame_err === 1'b1) n_err++;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    function automatic void put(ref afc_bq_t q, input logic [7:0] b, input logic [1:0] m);
        if (m == 2'h2 && b inside {8'h7e, 8'h7d, 8'h11, 8'h13}) begin
            q.push_back(8'h7d);
            q.push_back(b ^ 8'h20);
        end else begin
            q.push_back(b);
        end
    endfunction
    function automatic afc_bq_t frame(input afc_bq_t d, input logic [1:0] m, input logic [7:0] bad);
        afc_bq_t q;
        logic [7:0] sum;
        q = {8'h7e};
        sum = 8'h00;
        put(q, 8'(d.size() >> 8), m);
        put(q, 8'(d.size()), m);
        foreach (d[i]) begin
            put(q, d[i], m);
            sum = sum + d[i];
        end
        put(q, (8'hff - sum) ^ bad, m);
        return q;
    endfunction
    function automatic afc_bq_t rnd(input int n);
        afc_bq_t d;
        for (int i = 0; i < n; i++) d.push_back(($random(seed) & 1) ? 8'($random(seed)) : sp[i & 3]);
        return d;
    endfunction
    task automatic rx_frames(input logic [1:0] m, input int n);
        for (int f = 0; f < n; f++) begin
            afc_bq_t d;
            d = rnd(1 + f % 6);
            host_u.send(frame(d, m, 8'h00));
            foreach (d[i]) exp_q.push_back({i == 0, i == d.size() - 1, d[i]});
        end
        ok_exp += n;
    endtask
    task automatic settle(input string name);
        int i;
        i = 0;
        while (got_q.size() < exp_q.size() && i < 3000) begin
            @(posedge sys_clk);
            i++;
        end
        repeat (20) @(posedge sys_clk);
        check("frames good", n_ok, ok_exp);
        check("frames dropped", n_err, err_exp);
        check("bytes delivered", got_q.size(), exp_q.size());
        foreach (exp_q[k]) if (k < got_q.size()) check("delivered", got_q[k], exp_q[k]);
        got_q.delete();
        exp_q.delete();
        n_ok = 0;
        n_err = 0;
        ok_exp = 0;
        err_exp = 0;
        $display("test %s done: %0d checks, %0d wrong", name, cmp_count, n_fail);
    endtask
    // mode 0 keeps start high throughout: it must be ignored there
    task automatic tx_frame(input logic [1:0] m, input afc_bq_t d);
        afc_bq_t w;
        int i;
        if (m == 2'h0) w = d;
        else w = frame(d, m, 8'h00);
        host_u.cap_q.delete();
        api_mode_select <= m;
        tx_start <= 1'b1;
        tx_len <= 16'(d.size());
        @(posedge sys_clk);
        for (i = 0; m != 2'h0 && tx_busy !== 1'b1 && i < 100; i++) @(posedge sys_clk);
        if (m != 2'h0) tx_start <= 1'b0;
        foreach (d[k]) begin
            tx_valid <= 1'b1;
            tx_data <= d[k];
            @(posedge sys_clk);
            while (tx_ready !== 1'b1) @(posedge sys_clk);
        end
        tx_valid <= 1'b0;
        tx_start <= 1'b0;
        for (i = 0; host_u.cap_q.size() < w.size() && i < 500; i++) @(posedge sys_clk);
        repeat (10) @(posedge sys_clk);
        check("sent count", host_u.cap_q.size(), w.size());
        foreach (w[k]) if (k < host_u.cap_q.size()) check("sent", host_u.cap_q[k], w[k]);
        $display("test send mode %0d done: %0d wrong", m, n_fail);
    endtask
    task automatic finish_test();
        $display("checks %0d, wrong %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end
    initial begin
        afc_bq_t d;
        {sys_clk, rst, api_mode_select, hold_rx, rx_ready} = 6'h14;
        {tx_start, tx_len, tx_valid, tx_data} = 26'h0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        host_u.send({8'h00, 8'h55, 8'h7d});
        rx_frames(2'h1, 8);
        host_u.send(frame({8'h08, 8'h17}, 2'h1, 8'h5a));
        err_exp++;
        rx_frames(2'h1, 2);
        settle("framed receive");
        api_mode_select <= 2'h2;
        host_u.send({8'h7e, 8'h00, 8'h05, 8'h01, 8'h02});
        err_exp++;
        rx_frames(2'h2, 8);
        settle("escaped receive");
        for (int m = 1; m < 3; m++) begin
            tx_frame(2'(m), {8'h23, 8'h11});
            for (int k = 0; k < 4; k++) tx_frame(2'(m), rnd(1 + k * 2));
        end
        api_mode_select <= 2'h0;
        hold_rx <= 1'b1;
        d = rnd(20);
        foreach (d[i]) exp_q.push_back({2'b00, d[i]});
        host_u.refused = 1'b0;
        fork
            host_u.send(d);
        join_none
        repeat (100) @(posedge sys_clk);
        check("buffer full stall", host_u.refused, 1'b1);
        hold_rx <= 1'b0;
        wait fork;
        settle("raw receive");
        tx_frame(2'h0, rnd(6));
        finish_test();
    end
endmodule
bind afc_codec afc_codec_assertions chk_u (.sys_clk(sys_clk), .rst(rst),
    .api_mode_select(api_mode_select), .uart_rx_ready(uart_rx_ready),
    .uart_tx_valid(uart_tx_valid), .uart_tx_byte(uart_tx_byte), .uart_tx_ready(uart_tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_first(rx_first), .rx_last(rx_last),
    .rx_ready(rx_ready), .rx_frame_ok(rx_frame_ok), .rx_frame_err(rx_frame_err),
    .tx_busy(tx_busy));
